// File: usbev_pkg.sv
package usbev_pkg;
	// ==================================================
	// Register byte addresses
	localparam logic [31:0] USBEV_TOP_EVENT_ADDR = 32'h5000180C;
	localparam logic [31:0] USBEV_TOP_MASK_ADDR = 32'h5000180E;
	localparam logic [31:0] USBEV_BUS_EVENT_ADDR = 32'h50001810;
	localparam logic [31:0] USBEV_BUS_MASK_ADDR = 32'h50001812;
	localparam logic [31:0] USBEV_TX_EVENT_ADDR = 32'h50001814;
	localparam logic [31:0] USBEV_TX_MASK_ADDR = 32'h50001816;

	// ==================================================
	// Field positions
	localparam int USBEV_TOP_WARN_BIT = 0;
	localparam int USBEV_TOP_BUS_BIT = 1;
	localparam int USBEV_TOP_TX_BIT = 2;
	localparam int USBEV_TOP_FRAME_BIT = 3;
	localparam int USBEV_TOP_NAK_BIT = 4;
	localparam int USBEV_MASTER_BIT = 7;
	localparam int USBEV_BUS_LSB = 3;
	localparam int USBEV_BUS_MSB = 7;
	localparam int USBEV_PKT_END_IDX = 0;
	localparam int USBEV_IDLE3_IDX = 1;
	localparam int USBEV_IDLE5_IDX = 2;
	localparam int USBEV_BUS_RESET_IDX = 3;
	localparam int USBEV_WAKE_IDX = 4;
	localparam int USBEV_TX_DONE_LSB = 0;
	localparam int USBEV_TRANSMIT_UNDERFLOW_LSB = 4;

	// ==================================================
	// Reset values
	localparam logic [4:0] USBEV_TOP_MASK_RST = 5'h00;
	localparam logic USBEV_MASTER_RST = 1'b0;
	localparam logic [4:0] USBEV_BUS_RST = 5'h00;
	localparam logic [2:0] USBEV_TX_RST = 3'h0;
	localparam logic [15:0] USBEV_DATA_RST = 16'h0000;

	// ==================================================
	// Timing
	localparam int USBEV_CLOCK_HZ = 25000000;
	localparam real USBEV_SE0_RESET_US = 2.5;
	localparam int USBEV_IDLE3_MS = 3;
	localparam int USBEV_IDLE5_MS = 5;
	localparam int USBEV_SE0_CYCLES_I = int'($ceil(USBEV_SE0_RESET_US * USBEV_CLOCK_HZ / 1.0E6));
	localparam logic [6:0] USBEV_SE0_CYCLES = 7'(USBEV_SE0_CYCLES_I);
	localparam int USBEV_IDLE3_CYCLES = USBEV_IDLE3_MS * (USBEV_CLOCK_HZ / 1000);
	localparam int USBEV_IDLE5_CYCLES = USBEV_IDLE5_MS * (USBEV_CLOCK_HZ / 1000);

	// ==================================================
	// Carriers
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] wdata;
		logic write;
		logic read;
	} usbev_bus_s;

	typedef struct packed {
		logic se0;
		logic idle;
		logic suspended;
		logic packet_end;
	} usbev_line_s;

	typedef struct packed {
		logic [2:0] done_set;
		logic [2:0] underflow_set;
		logic [2:0] status_read;
	} usbev_tx_s;

	typedef struct packed {
		logic warn;
		logic frame;
		logic nak;
	} usbev_summ_s;

	typedef struct packed {
		logic [4:0] top_mask;
		logic master_en;
		logic [4:0] bus_flags;
		logic [4:0] bus_mask;
		logic [2:0] tx_done;
		logic [2:0] transmit_underflow;
		logic [2:0] tx_done_mask;
		logic [2:0] transmit_underflow_mask;
		logic bus_summary;
		logic tx_summary;
		logic [6:0] se0_count;
		logic [17:0] idle_count;
		logic busy_prev;
		logic [15:0] rdata;
		logic irq;
	} usbev_state_s;
endpackage : usbev_pkg

// File: usbev_events.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Low five top mask bits gate their top-level events toward the interrupt.
// - Bus leaving idle while suspended sets wake-up flag, bit 7.
// - SE0 held 2.5 us sets bus-reset flag, bit 6.
// - 5 ms continuous idle sets idle_5ms_flag, bit 5.
// - 3 ms continuous idle sets idle_3ms_flag, bit 4.
// - Valid end-of-packet sets packet_end_flag, bit 3.
// - Reading bus-condition flags clears them; reserved bits read zero.
// - Enabled bus-condition events set the bus-condition summary bit.
// - Transmit bits 6:4 mirror endpoint 3..1 underflow.
// - Underflow clears on reading that endpoint's transmit status.
// - Transmit bits 2:0 mirror endpoint 3..1 IN completion.
// - Done clears on reading that endpoint's status; reserved bits read zero.
// - Bus-condition summary marks unmasked event, clears on flag register read.
// - Transmit summary set by unmasked bit, clears when all bits clear.
// - Transmit mask bits decide which transmit bits reach the summary.
module usbev_events #(
	parameter int IDLE3_CYCLES = usbev_pkg::USBEV_IDLE3_CYCLES,
	parameter int IDLE5_CYCLES = usbev_pkg::USBEV_IDLE5_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire usbev_pkg::usbev_bus_s bus,
	input wire usbev_pkg::usbev_line_s line,
	input wire usbev_pkg::usbev_tx_s tx,
	input wire usbev_pkg::usbev_summ_s summ,
	output logic [15:0] rdata,
	output logic irq
);
	import usbev_pkg::*;

	// ==================================================
	// State
	usbev_state_s state_reg;
	usbev_state_s state_next;

	// ==================================================
	// Register select
	typedef enum logic [2:0] {
		USBEV_SEL_NONE = 3'h0,
		USBEV_SEL_TOP_EVENT = 3'h1,
		USBEV_SEL_TOP_MASK = 3'h3,
		USBEV_SEL_BUS_EVENT = 3'h2,
		USBEV_SEL_BUS_MASK = 3'h6,
		USBEV_SEL_TX_EVENT = 3'h7,
		USBEV_SEL_TX_MASK = 3'h5
	} usbev_sel_e;

	// Decoded once and shared by writes, reads and the read-clear
	function automatic usbev_sel_e decode(input logic [31:0] a);
		case (a)
			USBEV_TOP_EVENT_ADDR: begin
				decode = USBEV_SEL_TOP_EVENT;
			end
			USBEV_TOP_MASK_ADDR: begin
				decode = USBEV_SEL_TOP_MASK;
			end
			USBEV_BUS_EVENT_ADDR: begin
				decode = USBEV_SEL_BUS_EVENT;
			end
			USBEV_BUS_MASK_ADDR: begin
				decode = USBEV_SEL_BUS_MASK;
			end
			USBEV_TX_EVENT_ADDR: begin
				decode = USBEV_SEL_TX_EVENT;
			end
			USBEV_TX_MASK_ADDR: begin
				decode = USBEV_SEL_TX_MASK;
			end
			default: begin
				decode = USBEV_SEL_NONE;
			end
		endcase
	endfunction : decode

	// ==================================================
	// Helpers
	// Parks at the limit so a long line condition flags once per episode
	function automatic logic [17:0] sat_step(input logic [17:0] count, input logic [17:0] limit);
		if (count == limit) begin
			sat_step = count;
		end else begin
			sat_step = count + 18'h00001;
		end
	endfunction : sat_step

	// True on the sample that completes a run of limit samples
	function automatic logic reached(input logic [17:0] count, input logic [17:0] limit);
		reached = count == limit - 18'h00001;
	endfunction : reached

	// Set wins when an endpoint event and its status read share a cycle
	function automatic logic [2:0] mirror(input logic [2:0] flags, input logic [2:0] clear, input logic [2:0] set);
		mirror = (flags & ~clear) | set;
	endfunction : mirror

	function automatic logic [15:0] bus_word(input logic [4:0] bits);
		bus_word = USBEV_DATA_RST;
		bus_word[USBEV_BUS_MSB:USBEV_BUS_LSB] = bits;
	endfunction : bus_word

	function automatic logic [15:0] tx_word(input logic [2:0] done, input logic [2:0] urun);
		tx_word = USBEV_DATA_RST;
		tx_word[USBEV_TX_DONE_LSB+2:USBEV_TX_DONE_LSB] = done;
		tx_word[USBEV_TRANSMIT_UNDERFLOW_LSB+2:USBEV_TRANSMIT_UNDERFLOW_LSB] = urun;
	endfunction : tx_word

	function automatic logic [4:0] top_events(input usbev_state_s s, input usbev_summ_s m);
		top_events = 5'h00;
		top_events[USBEV_TOP_WARN_BIT] = m.warn;
		top_events[USBEV_TOP_BUS_BIT] = s.bus_summary;
		top_events[USBEV_TOP_TX_BIT] = s.tx_summary;
		top_events[USBEV_TOP_FRAME_BIT] = m.frame;
		top_events[USBEV_TOP_NAK_BIT] = m.nak;
	endfunction : top_events

	usbev_sel_e sel;
	logic [4:0] bus_set;
	logic bus_read;
	logic [17:0] se0_lim;
	logic [17:0] idle3_lim;
	logic [17:0] idle5_lim;
	logic [15:0] rd_word;
	logic [4:0] top_now;

	assign idle3_lim = 18'(IDLE3_CYCLES);
	assign idle5_lim = 18'(IDLE5_CYCLES);
	assign se0_lim = {11'h000, USBEV_SE0_CYCLES};

	// ==================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		sel = decode(bus.addr);
		bus_read = bus.read && sel == USBEV_SEL_BUS_EVENT;
		bus_set = 5'h00;

		// Line condition timers; the SE0 limit is 2.5 us rounded up to whole cycles
		if (line.se0) begin
			state_next.se0_count = 7'(sat_step({11'h000, state_reg.se0_count}, se0_lim));
			if (reached({11'h000, state_reg.se0_count}, se0_lim)) begin
				bus_set[USBEV_BUS_RESET_IDX] = 1'h1;
			end
		end else begin
			state_next.se0_count = 7'h00;
		end
		if (line.idle) begin
			state_next.idle_count = sat_step(state_reg.idle_count, idle5_lim);
			if (reached(state_reg.idle_count, idle3_lim)) begin
				bus_set[USBEV_IDLE3_IDX] = 1'h1;
			end
			if (reached(state_reg.idle_count, idle5_lim)) begin
				bus_set[USBEV_IDLE5_IDX] = 1'h1;
			end
		end else begin
			state_next.idle_count = 18'h00000;
		end
		state_next.busy_prev = !line.idle;
		if (line.suspended && !line.idle && !state_reg.busy_prev) begin
			bus_set[USBEV_WAKE_IDX] = 1'b1;
		end
		bus_set[USBEV_PKT_END_IDX] = line.packet_end;

		// Read clears, a new event in the same cycle wins
		state_next.bus_flags = (bus_read ? 5'h00 : state_reg.bus_flags) | bus_set;
		state_next.bus_summary = (bus_read ? 1'b0 : state_reg.bus_summary) | (|(bus_set & state_reg.bus_mask));

		// Transmit mirrors, cleared by endpoint status reads
		state_next.tx_done = mirror(state_reg.tx_done, tx.status_read, tx.done_set);
		state_next.transmit_underflow = mirror(state_reg.transmit_underflow, tx.status_read, tx.underflow_set);
		state_next.tx_summary = (|(state_next.tx_done & state_reg.tx_done_mask))
			| (|(state_next.transmit_underflow & state_reg.transmit_underflow_mask))
			| (state_reg.tx_summary && (|state_next.tx_done || |state_next.transmit_underflow));

		// Register writes
		if (bus.write) begin
			case (sel)
				USBEV_SEL_TOP_MASK: begin
					state_next.top_mask = bus.wdata[4:0];
					state_next.master_en = bus.wdata[USBEV_MASTER_BIT];
				end
				USBEV_SEL_BUS_MASK: begin
					state_next.bus_mask = bus.wdata[USBEV_BUS_MSB:USBEV_BUS_LSB];
				end
				USBEV_SEL_TX_MASK: begin
					state_next.tx_done_mask = bus.wdata[USBEV_TX_DONE_LSB+2:USBEV_TX_DONE_LSB];
					state_next.transmit_underflow_mask = bus.wdata[USBEV_TRANSMIT_UNDERFLOW_LSB+2:USBEV_TRANSMIT_UNDERFLOW_LSB];
				end
				default: begin
					state_next.top_mask = state_reg.top_mask;
				end
			endcase
		end

		// Register reads, unmapped addresses and reserved bits return zero
		top_now = top_events(state_reg, summ);
		rd_word = USBEV_DATA_RST;
		case (sel)
			USBEV_SEL_TOP_EVENT: begin
				rd_word[4:0] = top_now;
			end
			USBEV_SEL_TOP_MASK: begin
				rd_word[4:0] = state_reg.top_mask;
				rd_word[USBEV_MASTER_BIT] = state_reg.master_en;
			end
			USBEV_SEL_BUS_EVENT: begin
				rd_word = bus_word(state_reg.bus_flags);
			end
			USBEV_SEL_BUS_MASK: begin
				rd_word = bus_word(state_reg.bus_mask);
			end
			USBEV_SEL_TX_EVENT: begin
				rd_word = tx_word(state_reg.tx_done, state_reg.transmit_underflow);
			end
			USBEV_SEL_TX_MASK: begin
				rd_word = tx_word(state_reg.tx_done_mask, state_reg.transmit_underflow_mask);
			end
			default: begin
				rd_word = USBEV_DATA_RST;
			end
		endcase
		state_next.rdata = bus.read ? rd_word : USBEV_DATA_RST;

		state_next.irq = state_reg.master_en && (|(top_now & state_reg.top_mask));
	end

	// ==================================================
	// Registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= '{
				top_mask: USBEV_TOP_MASK_RST,
				master_en: USBEV_MASTER_RST,
				bus_flags: USBEV_BUS_RST,
				bus_mask: USBEV_BUS_RST,
				tx_done: USBEV_TX_RST,
				transmit_underflow: USBEV_TX_RST,
				tx_done_mask: USBEV_TX_RST,
				transmit_underflow_mask: USBEV_TX_RST,
				bus_summary: 1'b0,
				tx_summary: 1'b0,
				se0_count: 7'h00,
				idle_count: 18'h00000,
				busy_prev: 1'b0,
				rdata: USBEV_DATA_RST,
				irq: 1'b0
			};
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata = state_reg.rdata;
	assign irq = state_reg.irq;
endmodule : usbev_events
`default_nettype wire

// File: usbev_props.sv
`timescale 1ns/1ps
`default_nettype none
module usbev_props import usbev_pkg::*; #(parameter int IDLE3_CYCLES = 30, parameter int IDLE5_CYCLES = 50) (
	input wire logic clock,
	input wire logic rst,
	input wire usbev_pkg::usbev_bus_s bus,
	input wire usbev_pkg::usbev_line_s line,
	input wire usbev_pkg::usbev_tx_s tx,
	input wire usbev_pkg::usbev_summ_s summ,
	input wire logic [15:0] rdata,
	input wire logic irq
);
	// ==========
	// Decoded reads and a line with nothing to flag
	logic rd_bus, rd_tx, quiet;
	assign rd_bus = bus.read && bus.addr == USBEV_BUS_EVENT_ADDR;
	assign rd_tx = bus.read && bus.addr == USBEV_TX_EVENT_ADDR;
	assign quiet = !line.se0 && !line.idle && !line.packet_end && !line.suspended;
	// ==========
	// Properties
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	rdata_rest_a: assert property (!bus.read |=> rdata == 16'h0000) else $error("rdata");
	bus_resv_a: assert property (rd_bus |=> rdata[15:8] == 8'h00 && rdata[2:0] == 3'h0) else $error("bus resv");
	tx_resv_a: assert property (rd_tx |=> rdata[15:7] == 9'h000 && !rdata[3]) else $error("tx resv");
	read_clear_a: assert property (rd_bus && quiet ##1 rd_bus && quiet |=> rdata == 16'h0000) else $error("clear");
	eop_flag_a: assert property (line.packet_end ##1 rd_bus |=> rdata[3]) else $error("eop");
	tx_done_a: assert property (tx.done_set[0] ##1 rd_tx && !tx.status_read[0] |=> rdata[0]) else $error("done");
	transmit_underflow_a: assert property (tx.underflow_set[2] ##1 rd_tx && !tx.status_read[2] |=> rdata[6]) else $error("urun");
	tx_clear_a: assert property (tx.status_read[0] && !tx.done_set[0] ##1 rd_tx && !tx.done_set[0] |=> !rdata[0]) else $error("txclr");
	cover property (rd_bus ##1 rdata[6]);
	cover property (tx.done_set[0] ##1 rd_tx);
	cover property ($rose(irq));
	cover property (line.suspended && !line.idle ##1 rd_bus ##1 rdata[7]);
endmodule : usbev_props
`default_nettype wire

// File: usbev_host.sv
`timescale 1ns/1ps
`default_nettype none
module usbev_host import usbev_pkg::*; (
	input wire logic clock,
	input wire logic suspended,
	output wire usbev_pkg::usbev_line_s line
);
	// ==========
	// Line levels; the bus rests in idle
	logic se0 = 1'b0;
	logic idle = 1'b1;
	logic eop = 1'b0;
	assign line = '{se0: se0, idle: idle, suspended: suspended, packet_end: eop};
	task automatic drive(input logic s, input logic i, input logic e, input int n);
		se0 <= s;
		idle <= i;
		eop <= e;
		repeat (n) @(posedge clock);
		#1;
	endtask : drive
endmodule : usbev_host
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import usbev_pkg::*;
	localparam logic [31:0] TE = USBEV_TOP_EVENT_ADDR, TM = USBEV_TOP_MASK_ADDR, BE = USBEV_BUS_EVENT_ADDR;
	localparam logic [31:0] BM = USBEV_BUS_MASK_ADDR, XE = USBEV_TX_EVENT_ADDR, XM = USBEV_TX_MASK_ADDR;
	logic clock = 1'b0, rst = 1'b1, susp = 1'b0, irq;
	logic [15:0] rdata;
	logic [31:0] addrs [7] = '{TE, TM, BE, BM, XE, XM, 32'h50001818};
	usbev_bus_s bus = '0;
	usbev_tx_s tx = '0;
	usbev_summ_s summ = '0;
	usbev_line_s line;
	int fails = 0, check_count = 0, cycles = 0;
	always #20 clock = ~clock;
	usbev_events #(.IDLE3_CYCLES(30), .IDLE5_CYCLES(50)) i_dut (.clock(clock), .rst(rst), .bus(bus), .line(line),
		.tx(tx), .summ(summ), .rdata(rdata), .irq(irq));
	usbev_host i_host (.clock(clock), .suspended(susp), .line(line));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic rd(input logic [31:0] a, input logic [15:0] e);
		bus <= '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
		@(posedge clock);
		bus <= '0;
		#1;
		chk(rdata, e, $sformatf("read %h", a));
	endtask : rd
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
		@(posedge clock);
		bus <= '0;
		#1;
	endtask : wr
	task automatic txp(input logic [8:0] v);
		tx <= v;
		@(posedge clock);
		tx <= '0;
		#1;
	endtask : txp
	task automatic irq_is(input logic e);
		repeat (3) @(posedge clock);
		#1;
		chk({15'h0000, irq}, {15'h0000, e}, "irq");
	endtask : irq_is
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			results();
		end
	end
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		#1;
		for (int k = 0; k < 7; k++) rd(addrs[k], 16'h0000);
		i_host.drive(1'b0, 1'b0, 1'b0, 1);
		wr(TM, 16'h0087);
		rd(TM, 16'h0087);
		wr(BM, 16'h00F8);
		wr(XM, 16'h0077);
		i_host.drive(1'b0, 1'b1, 1'b0, 60);
		rd(TE, 16'h0002);
		irq_is(1'b1);
		i_host.drive(1'b0, 1'b0, 1'b0, 0);
		rd(BE, 16'h0030);
		rd(BE, 16'h0000);
		rd(TE, 16'h0000);
		i_host.drive(1'b1, 1'b0, 1'b0, 62);
		i_host.drive(1'b0, 1'b0, 1'b0, 1);
		rd(BE, 16'h0000);
		i_host.drive(1'b1, 1'b0, 1'b0, 63);
		i_host.drive(1'b0, 1'b0, 1'b1, 1);
		i_host.drive(1'b0, 1'b0, 1'b0, 0);
		rd(BE, 16'h0048);
		i_host.drive(1'b0, 1'b1, 1'b0, 35);
		rd(BE, 16'h0010);
		susp <= 1'b1;
		i_host.drive(1'b0, 1'b0, 1'b0, 1);
		rd(BE, 16'h0080);
		susp <= 1'b0;
		wr(BM, 16'h0000);
		i_host.drive(1'b0, 1'b0, 1'b1, 1);
		i_host.drive(1'b0, 1'b0, 1'b0, 0);
		rd(TE, 16'h0000);
		rd(BE, 16'h0008);
		txp(9'h060);
		rd(XE, 16'h0041);
		rd(TE, 16'h0004);
		txp(9'h001);
		rd(XE, 16'h0040);
		rd(TE, 16'h0004);
		txp(9'h004);
		rd(TE, 16'h0000);
		wr(XM, 16'h0070);
		txp(9'h080);
		rd(XE, 16'h0002);
		rd(TE, 16'h0000);
		summ.warn <= 1'b1;
		irq_is(1'b1);
		rd(TE, 16'h0001);
		summ <= '1;
		rd(TE, 16'h0019);
		wr(TM, 16'h0007);
		irq_is(1'b0);
		wr(TM, 16'h0086);
		irq_is(1'b0);
		wr(TM, 16'h0090);
		irq_is(1'b1);
		results();
	end
endmodule : testbench
bind usbev_events usbev_props #(.IDLE3_CYCLES(IDLE3_CYCLES), .IDLE5_CYCLES(IDLE5_CYCLES)) i_props (.clock(clock),
	.rst(rst), .bus(bus), .line(line), .tx(tx), .summ(summ), .rdata(rdata), .irq(irq));
`default_nettype wire
